// File: rtl/bmc_pkg.sv
// shared constants for the burst page-mode dram controller
package bmc_pkg;
  // configuration word layout, taken from the address bus of the first data-channel word read
  localparam int CFG_SIZE_LSB = 0;
  localparam int CFG_MODE_LSB = 3;
  localparam int CFG_RATE_LSB = 8;
  localparam int CFG_RATE_W = 8;
  localparam int CFG_BYTE_ORDER_BIT = 16;
  localparam int CFG_RAS3_BIT = 17;
  localparam int CFG_BWR1_BIT = 18;
  localparam int CFG_BLOCK_LSB = 19;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;

  // dram density codes
  localparam logic [2:0] SZ_64K = 3'h0;
  localparam logic [2:0] SZ_256K = 3'h1;
  localparam logic [2:0] SZ_1M = 3'h2;
  localparam logic [2:0] SZ_4M = 3'h3;
  localparam logic [2:0] SZ_16M = 3'h4;

  // row strobe period of a simple access, in clocks
  localparam logic [2:0] RAS_SHORT = 3'h3;
  localparam logic [2:0] RAS_LONG = 3'h4;

  // buffer control modes
  localparam logic [1:0] MODE_SPLIT_TX = 2'h0;
  localparam logic [1:0] MODE_SPLIT_CE = 2'h1;
  localparam logic [1:0] MODE_SHARED_TX = 2'h2;
  localparam logic [1:0] MODE_SHARED_CE = 2'h3;

  // transfer size codes on the option pins
  localparam logic [2:0] OPT_WORD = 3'h0;
  localparam logic [2:0] OPT_BYTE = 3'h1;
  localparam logic [2:0] OPT_HALF = 3'h2;

  // refresh interval is (rate + 1) << REF_UNIT_SHIFT clocks
  localparam int REF_UNIT_SHIFT = 4;

  // avalon register byte offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONFIG = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [3:0] REG_REF_COUNT = 4'hc;
  localparam logic CTRL_REF_EN_RST = 1'b1;
  localparam logic [15:0] REF_COUNT_RST = 16'h0000;
endpackage

// File: rtl/bmc_refresh_timer.sv
// refresh interval timer with a sticky request flag
`timescale 1ns/1ps
module bmc_refresh_timer #(
  parameter int RATE_W = bmc_pkg::CFG_RATE_W,
  parameter int UNIT_SHIFT = bmc_pkg::REF_UNIT_SHIFT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [RATE_W-1:0] rate,
  input wire logic ack,
  output logic pending
);
  localparam int CW = RATE_W + UNIT_SHIFT;
  logic [CW-1:0] count;
  wire due = enable && count == '0;
  wire [CW-1:0] reload = {rate, {UNIT_SHIFT{1'b1}}};
  wire [CW-1:0] next_count = (!enable || due) ? reload : CW'(count - 1'b1);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count <= '0;
      pending <= 1'b0;
    end
    else
    begin
      count <= next_count;
      pending <= due || (pending && !ack); // set wins over ack
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_ref_due_sets: assert property (due |=> pending)
    else $error("refresh interval expired without a request");
  chk_ref_set_wins: assert property ((due && ack) |=> pending)
    else $error("refresh request lost when set and ack coincide");
  chk_ref_ack_clears: assert property ((pending && ack && !due) |=> !pending)
    else $error("refresh request not cleared by ack");
endmodule

// File: rtl/bmc_dram_ctrl.sv
// burst page-mode dram controller: channel handshake, two interleaved banks, refresh
// How it works
// - two 32-bit banks, each with its own address, strobe and write outputs
// - each bank gets an 11-bit bus carrying row then column address
// - one active-low row strobe per bank marks a valid row address
// - four active-low column strobes per bank, one per byte lane
// - one write strobe per bank, both always carrying the same waveform
// - per-bank latch enable is high only during data write cycles
// - four buffer controls change function with the buffer mode, mode zero default
// - mode zero: per-bank data transmit low during data reads
// - mode zero: per-bank instruction transmit low during instruction cycles
// - refresh cycles are generated on its own at the configured rate
// - competing instruction and data requests are served one after another
// - simple, pipelined and burst accesses on both channels
// - bursts alternate banks so one word moves every clock, every two clocks for writes while configuration bit 18 is clear
// - data words have four separately strobed byte lanes for 8, 16, 32 bits
// - densities 64 Kbit to 16 Mbit, chosen by configuration
// - configuration sets block address, refresh rate, byte order, buffers, size
// - the first data-channel word read after reset is taken as the configuration
// - once configured the chained reset output is released
// - chained reset output is low in reset and until configured
// - after configuration only addresses in the size-aligned block are served
// - configuration bit 16 picks which data bits byte address 0 uses
// - configuration bit 17 picks a 3 or 4 clock row strobe period
`timescale 1ns/1ps
module bmc_dram_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] addr,
  input wire logic bus_invalid_n,
  input wire logic rd_wr,
  input wire logic data_req_n,
  input wire logic [1:0] data_req_type,
  input wire logic data_burst_req_n,
  input wire logic [2:0] opt,
  input wire logic instr_req_n,
  input wire logic instr_req_type,
  input wire logic instr_burst_req_n,
  output logic data_ready_n,
  output logic data_burst_ack_n,
  output logic instr_ready_n,
  output logic instr_burst_ack_n,
  output logic pipe_en_n,
  output logic data_ctl_oe,
  output logic instr_ctl_oe,
  output logic [10:0] mem_addr_a,
  output logic [10:0] mem_addr_b,
  output logic row_strobe_a_n,
  output logic row_strobe_b_n,
  output logic [3:0] col_strobe_a_n,
  output logic [3:0] col_strobe_b_n,
  output logic bank_write_strobe_a_n,
  output logic bank_write_strobe_b_n,
  output logic wr_latch_en_bank_a,
  output logic wr_latch_en_bank_b,
  output logic data_xmit_bank_a_n,
  output logic data_xmit_bank_b_n,
  output logic instr_xmit_bank_a_n,
  output logic instr_xmit_bank_b_n,
  output logic chain_reset_out_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef enum logic [2:0] {ST_IDLE, ST_CFG, ST_ROW, ST_COL, ST_PRE, ST_REF} bmc_state_t;
  bmc_state_t state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [29:0] word, next_word;
  logic [3:0] lanes, next_lanes;
  logic [31:0] cfg, next_cfg;
  logic is_write, next_is_write, is_instr, next_is_instr, is_burst, next_is_burst;
  logic half, next_half, configured, next_configured, ref_en, ref_pending;
  logic [15:0] ref_count;
  logic [31:0] av_rdata;
  // 16 Mbit parts are taken as nibble-wide, so they share the 11-bit row/column split
  function automatic logic [3:0] row_col_bits(input logic [2:0] size);
    case (size)
      bmc_pkg::SZ_64K: return 4'h8;
      bmc_pkg::SZ_256K: return 4'h9;
      bmc_pkg::SZ_1M: return 4'ha;
      default: return 4'hb;
    endcase
  endfunction
  function automatic logic [10:0] mux_addr(input logic [28:0] line, input logic [3:0] rc,
                                           input logic row);
    logic [28:0] s;
    s = row ? (line >> rc) : line;
    return s[10:0] & 11'((12'h1 << rc) - 12'h1);
  endfunction
  // big-endian numbering flips the lane index; misaligned halves are not detected
  function automatic logic [3:0] lane_mask(input logic [2:0] size, input logic [1:0] a,
                                           input logic big);
    logic [1:0] idx;
    idx = big ? ~a : a;
    case (size)
      bmc_pkg::OPT_BYTE: return 4'(4'h1 << idx);
      bmc_pkg::OPT_HALF: return idx[1] ? 4'hc : 4'h3;
      default: return 4'hf;
    endcase
  endfunction
  // decode of the configuration word
  wire [3:0] rc = row_col_bits(cfg[bmc_pkg::CFG_SIZE_LSB +: 3]);
  wire [4:0] blk_lsb = {rc, 1'b0} + 5'h3;
  wire [31:0] blk_mask = 32'hffff_ffff << blk_lsb;
  wire in_block = ((addr ^ cfg) & blk_mask) == 32'h0;
  wire big_end = cfg[bmc_pkg::CFG_BYTE_ORDER_BIT];
  wire [2:0] ras_len = cfg[bmc_pkg::CFG_RAS3_BIT] ? bmc_pkg::RAS_SHORT : bmc_pkg::RAS_LONG;
  wire [2:0] col_last = ras_len - 3'h2;
  wire [1:0] mode = cfg[bmc_pkg::CFG_MODE_LSB +: 2];
  wire bwr_slow = !cfg[bmc_pkg::CFG_BWR1_BIT];
  // request qualification and arbitration
  wire data_valid = bus_invalid_n && !data_req_n && data_req_type == 2'h0 &&
                    opt <= bmc_pkg::OPT_HALF;
  wire instr_valid = bus_invalid_n && !instr_req_n && !instr_req_type;
  wire cfg_take = !configured && data_valid && rd_wr && opt == bmc_pkg::OPT_WORD;
  wire take_data = configured && data_valid && in_block;
  wire take_instr = configured && instr_valid && in_block && !take_data;
  // refresh only starts from idle, so an open page is never broken
  wire ref_ack = state == ST_IDLE && configured && ref_pending;
  wire burst_held = is_instr ? !instr_burst_req_n : !data_burst_req_n;
  wire wr2 = is_burst && is_write && bwr_slow;
  wire ready_now = state == ST_COL && cnt >= col_last && (!wr2 || half);
  wire [28:0] col_mask = 29'((30'h1 << rc) - 30'h1);
  wire page_end = word[0] && ((word[29:1] & col_mask) == col_mask);
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_word = word;
    next_lanes = lanes;
    next_cfg = cfg;
    next_is_write = is_write;
    next_is_instr = is_instr;
    next_is_burst = is_burst;
    next_half = half;
    next_configured = configured;
    unique case (state)
      ST_IDLE:
      begin
        if (cfg_take)
        begin
          next_state = ST_CFG;
          next_cfg = addr;
          next_configured = 1'b1;
          next_is_instr = 1'b0;
        end
        else if (ref_ack)
        begin
          next_state = ST_REF;
          next_cnt = 3'h0;
        end
        else if (take_data || take_instr)
        begin
          next_state = ST_ROW;
          next_cnt = 3'h0;
          next_half = 1'b0;
          next_word = addr[31:2];
          next_is_instr = take_instr;
          next_is_write = take_data && !rd_wr;
          next_is_burst = take_instr ? !instr_burst_req_n : !data_burst_req_n;
          next_lanes = take_instr ? 4'hf : lane_mask(opt, addr[1:0], big_end);
        end
      end
      ST_CFG: next_state = ST_IDLE;
      ST_ROW: next_state = ST_COL;
      ST_COL:
      begin
        if (ready_now)
        begin
          if (is_burst && burst_held && !page_end)
          begin
            next_word = word + 30'h1;
            next_half = 1'b0;
          end
          else
            next_state = ST_PRE;
        end
        else if (cnt < col_last)
          next_cnt = cnt + 3'h1;
        else
          next_half = !half;
      end
      ST_PRE: next_state = ST_IDLE;
      ST_REF:
      begin
        if (cnt == ras_len)
          next_state = ST_PRE;
        else
          next_cnt = cnt + 3'h1;
      end
    endcase
    if (rst)
    begin
      next_state = ST_IDLE;
      next_cnt = 3'h0;
      next_word = 30'h0;
      next_lanes = 4'h0;
      next_cfg = bmc_pkg::CFG_RST;
      next_is_write = 1'b0;
      next_is_instr = 1'b0;
      next_is_burst = 1'b0;
      next_half = 1'b0;
      next_configured = 1'b0;
    end
  end

  // pin values decoded from the next state so every pin is a flop in phase with state
  wire n_col = next_state == ST_COL;
  wire n_open = next_state == ST_ROW || n_col;
  wire n_bank = next_word[0];
  wire n_ref_cas = next_state == ST_REF;
  wire n_ref_ras = n_ref_cas && next_cnt != 3'h0;
  wire n_row_a = (n_open && (next_is_burst || !n_bank)) || n_ref_ras;
  wire n_row_b = (n_open && (next_is_burst || n_bank)) || n_ref_ras;
  wire [10:0] n_addr = mux_addr(next_word[29:1], rc, next_state == ST_ROW);
  wire [3:0] n_cas_a = n_ref_cas ? 4'hf : ((n_col && !n_bank) ? next_lanes : 4'h0);
  wire [3:0] n_cas_b = n_ref_cas ? 4'hf : ((n_col && n_bank) ? next_lanes : 4'h0);
  wire n_we = n_col && next_is_write;
  wire n_dread = n_col && !next_is_instr && !next_is_write;
  wire n_dacc = n_col && !next_is_instr;
  wire n_instr = n_col && next_is_instr;
  wire n_bwr = next_is_burst && next_is_write;
  wire n_rdy = n_col && next_cnt >= col_last && (!(n_bwr && bwr_slow) || next_half);
  wire n_busy = n_open || next_state == ST_CFG;

  // buffer controls: split modes are per bank, shared modes carry a bank select
  wire split = !mode[1];
  wire ce = mode[0];
  wire n_dsel = ce ? n_dacc : n_dread;
  wire buf1 = split ? n_dsel && (!n_bank || (ce && n_bwr)) : n_dsel;
  wire buf2 = split ? n_dsel && (n_bank || (ce && n_bwr)) : n_bank;
  wire buf3 = n_instr && (!split || !n_bank);
  wire buf4 = n_instr && (!split || n_bank);

  always_ff @(posedge clk)
  begin
    state <= next_state;
    cnt <= next_cnt;
    word <= next_word;
    lanes <= next_lanes;
    cfg <= next_cfg;
    is_write <= next_is_write;
    is_instr <= next_is_instr;
    is_burst <= next_is_burst;
    half <= next_half;
    configured <= next_configured;
  end

  always_ff @(posedge clk)
  begin
    mem_addr_a <= n_addr;
    mem_addr_b <= n_addr;
    row_strobe_a_n <= !n_row_a;
    row_strobe_b_n <= !n_row_b;
    col_strobe_a_n <= ~n_cas_a;
    col_strobe_b_n <= ~n_cas_b;
    bank_write_strobe_a_n <= !n_we;
    bank_write_strobe_b_n <= !n_we;
    wr_latch_en_bank_a <= n_we && !next_is_instr && !n_bank;
    wr_latch_en_bank_b <= n_we && !next_is_instr && n_bank;
    data_xmit_bank_a_n <= !buf1;
    data_xmit_bank_b_n <= !buf2;
    instr_xmit_bank_a_n <= !buf3;
    instr_xmit_bank_b_n <= !buf4;
    data_ready_n <= !((n_rdy && !next_is_instr) || next_state == ST_CFG);
    instr_ready_n <= !(n_rdy && next_is_instr);
    data_burst_ack_n <= !(n_col && next_is_burst && !next_is_instr);
    instr_burst_ack_n <= !(n_col && next_is_burst && next_is_instr);
    pipe_en_n <= !n_col;
    data_ctl_oe <= n_busy && !next_is_instr;
    instr_ctl_oe <= n_busy && next_is_instr;
    chain_reset_out_n <= next_configured;
  end
  bmc_refresh_timer u_refresh (
    .clk(clk),
    .rst(rst),
    .enable(configured && ref_en),
    .rate(cfg[bmc_pkg::CFG_RATE_LSB +: bmc_pkg::CFG_RATE_W]),
    .ack(ref_ack),
    .pending(ref_pending)
  );

  // avalon slave: one wait cycle, then the answer stands for one cycle
  wire av_req = (avs_read || avs_write) && avs_waitrequest;
  wire av_wr_ctrl = avs_write && !avs_waitrequest && avs_address == bmc_pkg::REG_CTRL &&
                    avs_byteenable[0];
  always_comb
  begin
    case (avs_address)
      bmc_pkg::REG_STATUS: av_rdata = {29'h0, ref_pending, state != ST_IDLE, configured};
      bmc_pkg::REG_CONFIG: av_rdata = cfg;
      bmc_pkg::REG_CTRL: av_rdata = {31'h0, ref_en};
      bmc_pkg::REG_REF_COUNT: av_rdata = {16'h0, ref_count};
      default: av_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      ref_en <= bmc_pkg::CTRL_REF_EN_RST;
      ref_count <= bmc_pkg::REF_COUNT_RST;
    end
    else
    begin
      avs_waitrequest <= !av_req;
      avs_readdata <= (av_req && avs_read) ? av_rdata : 32'h0;
      if (av_wr_ctrl)
        ref_en <= avs_writedata[0];
      if (ref_ack)
        ref_count <= ref_count + 16'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_chain_in_reset: assert property (disable iff (1'b0) rst |=> !chain_reset_out_n)
    else $error("chained reset not low after reset");
  chk_cfg_release: assert property ((state == ST_IDLE && cfg_take)
    |=> !data_ready_n && chain_reset_out_n ##1 data_ready_n && chain_reset_out_n)
    else $error("configuration read not answered or chain not released");
  chk_unconfig_quiet: assert property (!configured |-> row_strobe_a_n && row_strobe_b_n)
    else $error("memory touched before configuration");
  chk_write_pair: assert property (bank_write_strobe_a_n == bank_write_strobe_b_n)
    else $error("bank write strobes differ");
  chk_ras_long: assert property ((state == ST_ROW && !is_burst && !word[0] &&
    !cfg[bmc_pkg::CFG_RAS3_BIT]) |-> !row_strobe_a_n [*4] ##1 row_strobe_a_n)
    else $error("row strobe period not four clocks");
  chk_ras_short: assert property ((state == ST_ROW && !is_burst && word[0] &&
    cfg[bmc_pkg::CFG_RAS3_BIT]) |-> !row_strobe_b_n [*3] ##1 row_strobe_b_n)
    else $error("row strobe period not three clocks");
  chk_latch_write: assert property ((wr_latch_en_bank_a || wr_latch_en_bank_b)
    |-> !bank_write_strobe_a_n && data_ctl_oe && instr_xmit_bank_a_n && instr_xmit_bank_b_n)
    else $error("write latch enabled outside a data write");
  chk_one_owner: assert property (!(data_ctl_oe && instr_ctl_oe))
    else $error("both channels served at once");
  chk_refresh_cbr: assert property ((state == ST_REF && cnt == 3'h1)
    |-> col_strobe_a_n == 4'h0 && !row_strobe_a_n && $past(row_strobe_a_n) &&
        $past(col_strobe_b_n) == 4'h0)
    else $error("refresh not column before row");
  chk_block_miss: assert property ((state == ST_IDLE && configured && !ref_pending &&
    data_valid && !in_block && !instr_valid) |=> state == ST_IDLE && data_ready_n)
    else $error("access outside the block was served");
  chk_byte_lane: assert property ((state == ST_IDLE && take_data && !ref_pending &&
    !rd_wr && opt == bmc_pkg::OPT_BYTE) |=> ##1 $countones(~(col_strobe_a_n & col_strobe_b_n)) == 1)
    else $error("byte write strobed more than one lane");
  chk_burst_alt: assert property ((!data_ready_n && !data_burst_ack_n && !is_write &&
    mode == bmc_pkg::MODE_SPLIT_TX && $past(!data_ready_n && !data_burst_ack_n))
    |-> data_xmit_bank_a_n != $past(data_xmit_bank_a_n))
    else $error("burst read did not alternate banks");
  cov_config: cover property (state == ST_IDLE && cfg_take);
  cov_burst_read: cover property (!instr_ready_n && !instr_burst_ack_n ##1 !instr_ready_n);
  cov_refresh: cover property (state == ST_REF ##1 state == ST_REF);
  cov_byte_write: cover property (state == ST_IDLE && take_data && !rd_wr &&
    opt == bmc_pkg::OPT_BYTE);
endmodule

// File: verification/bmc_chan_model.sv
// processor local channel model: issues requests and counts the controller's answers
`timescale 1ns/1ps
module bmc_chan_model (
  input wire logic clk,
  output logic [31:0] addr,
  output logic bus_invalid_n,
  output logic rd_wr,
  output logic data_req_n,
  output logic [1:0] data_req_type,
  output logic data_burst_req_n,
  output logic [2:0] opt,
  output logic instr_req_n,
  output logic instr_req_type,
  output logic instr_burst_req_n,
  input wire logic data_ready_n,
  input wire logic instr_ready_n
);
  int cyc;
  int words;
  int span;
  logic order_ok;
  initial
  begin
    addr = 32'h0000_0000;
    bus_invalid_n = 1'b1;
    rd_wr = 1'b1;
    {data_req_n, data_burst_req_n, instr_req_n, instr_burst_req_n} = 4'hf;
    data_req_type = 2'h0;
    instr_req_type = 1'b0;
    opt = 3'h0;
  end
  // callers keep sub-word addresses aligned and configure first, except the instruction probe in bring_up
  // request held until its last word; burst request drops one word early
  task automatic req(input logic [31:0] a, input logic rd, input logic ins, input logic [2:0] o,
                     input int nw, input int lim);
    int first;
    cyc = 0;
    words = 0;
    first = 0;
    span = 0;
    addr <= a;
    rd_wr <= rd;
    opt <= o;
    if (ins)
    begin
      instr_req_n <= 1'b0;
      instr_burst_req_n <= (nw < 2);
    end
    else
    begin
      data_req_n <= 1'b0;
      data_burst_req_n <= (nw < 2);
    end
    while (words < nw && cyc < lim)
    begin
      @(posedge clk);
      cyc++;
      if ((ins ? instr_ready_n : data_ready_n) === 1'b0)
      begin
        if (words == 0)
          first = cyc;
        words++;
        span = cyc - first;
        // the controller decides on the next word at the edge that takes this one
        if (words == nw - 1)
        begin
          data_burst_req_n <= 1'b1;
          instr_burst_req_n <= 1'b1;
        end
      end
    end
    // a released address bus does not keep its last value
    addr <= ~a;
    {data_req_n, data_burst_req_n, instr_req_n, instr_burst_req_n} <= 4'hf;
  endtask
  // data and instruction request raised together; the address follows whichever is served
  task automatic dual(input logic [31:0] da, input logic [31:0] ia);
    cyc = 0;
    order_ok = 1'b1;
    addr <= da;
    rd_wr <= 1'b1;
    opt <= 3'h0;
    data_req_n <= 1'b0;
    instr_req_n <= 1'b0;
    do
    begin
      @(posedge clk);
      cyc++;
      if (instr_ready_n === 1'b0)
        order_ok = 1'b0;
    end while (data_ready_n !== 1'b0 && cyc < 40);
    data_req_n <= 1'b1;
    addr <= ia;
    do
    begin
      @(posedge clk);
      cyc++;
    end while (instr_ready_n !== 1'b0 && cyc < 80);
    instr_req_n <= 1'b1;
    addr <= ~ia;
  endtask
endmodule

// File: verification/burst_page_mode_dram_controller_tb_top.sv
// self-checking bench for the dram controller: channel accesses and register reads
`timescale 1ns/1ps
module burst_page_mode_dram_controller_tb_top;
  localparam logic [31:0] CFG_A = 32'h0008_0000;
  localparam logic [31:0] CFG_B = 32'h000b_0000;
  localparam logic [31:0] BA = 32'h000a_d1e0;
  logic clk, rst, bus_invalid_n, rd_wr, data_req_n, data_burst_req_n, instr_req_n;
  logic instr_req_type, instr_burst_req_n, data_ready_n, data_burst_ack_n, instr_ready_n;
  logic instr_burst_ack_n, pipe_en_n, data_ctl_oe, instr_ctl_oe, row_strobe_a_n, row_strobe_b_n;
  logic bank_write_strobe_a_n, bank_write_strobe_b_n, wr_latch_en_bank_a, wr_latch_en_bank_b;
  logic data_xmit_bank_a_n, data_xmit_bank_b_n, instr_xmit_bank_a_n, instr_xmit_bank_b_n;
  logic chain_reset_out_n, avs_read, avs_write, avs_waitrequest, mon, we_diff;
  logic [31:0] addr, avs_writedata, avs_readdata, q, c1;
  logic [1:0] data_req_type;
  logic [2:0] opt;
  logic [3:0] col_strobe_a_n, col_strobe_b_n, avs_address, avs_byteenable;
  logic [10:0] mem_addr_a, mem_addr_b, row_a, col_a;
  logic [15:0] seen;
  int fail_count = 0;
  int num_checks = 0;
  bmc_dram_ctrl u_dut (.clk, .rst, .addr, .bus_invalid_n, .rd_wr, .data_req_n, .data_req_type,
    .data_burst_req_n, .opt, .instr_req_n, .instr_req_type, .instr_burst_req_n, .data_ready_n,
    .data_burst_ack_n, .instr_ready_n, .instr_burst_ack_n, .pipe_en_n, .data_ctl_oe,
    .instr_ctl_oe, .mem_addr_a, .mem_addr_b, .row_strobe_a_n, .row_strobe_b_n, .col_strobe_a_n,
    .col_strobe_b_n, .bank_write_strobe_a_n, .bank_write_strobe_b_n, .wr_latch_en_bank_a,
    .wr_latch_en_bank_b, .data_xmit_bank_a_n, .data_xmit_bank_b_n, .instr_xmit_bank_a_n,
    .instr_xmit_bank_b_n, .chain_reset_out_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  bmc_chan_model u_ch (.clk, .addr, .bus_invalid_n, .rd_wr, .data_req_n, .data_req_type,
    .data_burst_req_n, .opt, .instr_req_n, .instr_req_type, .instr_burst_req_n, .data_ready_n,
    .instr_ready_n);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // which strobes and buffer controls went active during one access
  always @(posedge clk)
  begin
    if (mon)
      seen <= seen | {~col_strobe_b_n, ~col_strobe_a_n, ~instr_xmit_bank_b_n,
        ~instr_xmit_bank_a_n, ~data_xmit_bank_b_n, ~data_xmit_bank_a_n, wr_latch_en_bank_b,
        wr_latch_en_bank_a, ~row_strobe_b_n, ~row_strobe_a_n};
    else
      seen <= 16'h0000;
    if (!row_strobe_a_n && col_strobe_a_n == 4'hf)
      row_a <= mem_addr_a;
    if (col_strobe_a_n != 4'hf)
      col_a <= mem_addr_a;
    if (bank_write_strobe_a_n !== bank_write_strobe_b_n || mem_addr_a !== mem_addr_b)
      we_diff <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    // no local limit: a slave that never answers is ended by the watchdog
    do
    begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic acc(input logic [31:0] a, input logic rd, input logic ins, input logic [2:0] o,
                     input int nw, input int lim);
    @(posedge clk);
    mon <= 1'b0;
    @(posedge clk);
    mon <= 1'b1;
    u_ch.req(a, rd, ins, o, nw, lim);
    repeat (3) @(posedge clk);
  endtask
  task automatic bring_up(input logic [31:0] cfg);
    av(1'b1, bmc_pkg::REG_CTRL, 32'h0000_0000);
    acc(BA, 1'b1, 1'b1, 3'h0, 1, 12);
    chk(u_ch.words, 0);
    chk(chain_reset_out_n, 1'b0);
    acc(cfg, 1'b1, 1'b0, 3'h0, 1, 20);
    chk(u_ch.words, 1);
    chk(chain_reset_out_n, 1'b1);
    av(1'b1, bmc_pkg::REG_CONFIG, 32'hffff_ffff);
    av(1'b0, bmc_pkg::REG_CONFIG, 32'h0);
    chk(q, cfg);
    av(1'b0, bmc_pkg::REG_STATUS, 32'h0);
    chk(q[0], 1'b1);
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #(20 * 20000);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    rst = 1'b1;
    mon = 1'b0;
    we_diff = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    repeat (20) @(posedge clk);
    chk(chain_reset_out_n, 1'b0);
    chk(avs_waitrequest, 1'b1);
    chk({row_strobe_a_n, row_strobe_b_n, col_strobe_a_n, col_strobe_b_n}, 10'h3ff);
    rst <= 1'b0;
    bring_up(CFG_A);
    acc(BA, 1'b1, 1'b0, 3'h0, 1, 40);
    chk(u_ch.cyc, 32'(bmc_pkg::RAS_LONG) + 1);
    chk(seen, 16'h0f11);
    chk(row_a, 11'h05a);
    chk(col_a, 11'h03c);
    acc(BA + 5, 1'b0, 1'b0, bmc_pkg::OPT_BYTE, 1, 40);
    chk(seen, 16'h200a);
    acc(BA + 2, 1'b0, 1'b0, bmc_pkg::OPT_HALF, 1, 40);
    chk(seen, 16'h0c05);
    acc(BA + 4, 1'b1, 1'b1, 3'h0, 1, 40);
    chk(seen, 16'hf082);
    acc(BA, 1'b1, 1'b0, 3'h0, 4, 60);
    chk(u_ch.words, 4);
    chk(u_ch.span, 3);
    chk(seen, 16'hff33);
    acc(32'h0010_0000, 1'b1, 1'b0, 3'h0, 1, 12);
    chk(u_ch.words, 0);
    @(posedge clk);
    u_ch.dual(BA, BA + 4);
    chk(u_ch.order_ok, 1'b1);
    chk(u_ch.cyc < 80, 1'b1);
    chk(we_diff, 1'b0);
    av(1'b0, bmc_pkg::REG_REF_COUNT, 32'h0);
    c1 = q;
    av(1'b1, bmc_pkg::REG_CTRL, 32'h0000_0001);
    repeat (100) @(posedge clk);
    av(1'b0, bmc_pkg::REG_REF_COUNT, 32'h0);
    // interval is 16 clocks at rate 0; a refresh takes a few clocks of its own
    chk((q - c1) >= 3 && (q - c1) <= 8, 1'b1);
    acc(BA, 1'b1, 1'b0, 3'h0, 1, 60);
    chk(u_ch.words, 1);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    chk(chain_reset_out_n, 1'b0);
    rst <= 1'b0;
    bring_up(CFG_B);
    acc(BA + 4, 1'b1, 1'b0, 3'h0, 1, 40);
    chk(u_ch.cyc, 32'(bmc_pkg::RAS_SHORT) + 1);
    acc(BA, 1'b0, 1'b0, 3'h0, 2, 60);
    chk(u_ch.span, 2);
    chk(seen, 16'hff0f);
    acc(BA + 4, 1'b1, 1'b1, 3'h0, 2, 60);
    chk(u_ch.span, 1);
    chk(seen, 16'hffc3);
    acc(BA + 1, 1'b0, 1'b0, bmc_pkg::OPT_BYTE, 1, 40);
    chk(seen, 16'h0405);
    print_verdict();
  end
endmodule
